/* rtcs_defines.svh */
// Offsets, field positions, reset values and timing figures of the RTC
// control and status block. Included by bare name; definitions only.
`ifndef RTCS_DEFINES_SVH
`define RTCS_DEFINES_SVH

// Register byte offsets
`define RTCS_OFS_CTRL       8'h00
`define RTCS_OFS_IRQ_STAT   8'h04
`define RTCS_OFS_IRQ_MASK   8'h08
`define RTCS_OFS_YEAR       8'h0C
`define RTCS_OFS_STATUS     8'h10

// Control register fields
`define RTCS_CTRL_CTE       0
`define RTCS_CTRL_CENTURY   1
`define RTCS_CTRL_HALT      2
`define RTCS_CTRL_FTEST     3
`define RTCS_CTRL_LEVEL     4
`define RTCS_CTRL_FAIL      5
`define RTCS_CTRL_W         6

// Interrupt status and mask fields
`define RTCS_IRQ_CENTURY    0
`define RTCS_IRQ_FAIL       1
`define RTCS_IRQ_W          2

// Status register fields
`define RTCS_STAT_POWER     0
`define RTCS_STAT_PIN_LOW   1
`define RTCS_STAT_W         2

// First power-up values
`define RTCS_RST_HALT       1'h0
`define RTCS_RST_FTEST      1'h0
`define RTCS_RST_LEVEL      1'h1
`define RTCS_RST_FAIL       1'h1
`define RTCS_RST_CTE        1'h0
`define RTCS_RST_CENTURY    1'h0
`define RTCS_RST_YEAR       8'h00

// BCD year limits
`define RTCS_BCD_NINE       4'h9
`define RTCS_BCD_ZERO       4'h0
`define RTCS_BCD_ONE        4'h1

// Oscillator and test output rates
`define RTCS_OSC_HZ         32768
`define RTCS_TEST_HZ        512
`define RTCS_DIV_W          5

// AXI responses
`define RTCS_RESP_OKAY      2'h0
`define RTCS_RESP_SLVERR    2'h2

`endif

/* rtcs_pkg.sv */
// Types shared by the RTC control and status block.
// Assumes the defines header is compiled alongside.
package rtcs_pkg;

	// Source that steers the open-drain test output
	typedef enum logic [1:0] {
		RTCS_PIN_LEVEL    = 2'b00,
		RTCS_PIN_SQUARE   = 2'b01,
		RTCS_PIN_RELEASED = 2'b10
	} rtcs_pin_mode_t;

endpackage

/* rtcs_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Assumes the pins are slow next to clk_sys; no glitch filtering.
`timescale 1ns/10ps
module rtcs_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_b,
	// Pins in, synchronised levels out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= pin_in;
			sync_out <= meta_q;
		end
	end

endmodule

/* rtcs_top.sv */
// RTC control and status bits behind an AXI4-Lite register slave.
// Assumes rst_b marks first power application and the pins are async.
`timescale 1ns/10ps
`include "rtcs_defines.svh"
module rtcs_top (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Oscillator and power pins
	input  wire logic        osc_clk_pin,
	input  wire logic        year_tick_pin,
	input  wire logic        supply_low_pin,
	input  wire logic        osc_disturb_pin,
	input  wire logic        main_power_pin,
	// Open-drain test output
	output logic             test_output_pin_o,
	output logic             test_output_pin_oe,
	// Interrupt
	output logic             irq
);

	localparam int HALF_EDGES = `RTCS_OSC_HZ / (2 * `RTCS_TEST_HZ);
	localparam logic [`RTCS_DIV_W-1:0] DIV_LAST =
		`RTCS_DIV_W'(HALF_EDGES - 1);

	// Synchronised pins
	logic [4:0] pins_s;
	logic       osc_s;
	logic       tick_s;
	logic       low_s;
	logic       dist_s;
	logic       pwr_s;

	rtcs_sync #(
		.WIDTH (5)
	) u_sync (
		.clk_sys  (clk_sys),
		.rst_b    (rst_b),
		.pin_in   ({main_power_pin, osc_disturb_pin, supply_low_pin,
		            year_tick_pin, osc_clk_pin}),
		.sync_out (pins_s)
	);

	assign osc_s  = pins_s[0];
	assign tick_s = pins_s[1];
	assign low_s  = pins_s[2];
	assign dist_s = pins_s[3];
	assign pwr_s  = pins_s[4];

	// Control bits and state
	logic                   cte_q;
	logic                   century_q;
	logic                   halt_q;
	logic                   ftest_q;
	logic                   level_q;
	logic                   fail_q;
	logic [7:0]             year_q;
	logic [`RTCS_IRQ_W-1:0] stat_q;
	logic [`RTCS_IRQ_W-1:0] mask_q;
	logic                   osc_prev_q;
	logic                   tick_prev_q;
	logic                   pwr_prev_q;
	logic [`RTCS_DIV_W-1:0] div_q;
	logic                   square_q;

	// Bus state
	logic [7:0]  wa_q;
	logic [31:0] wd_q;
	logic [3:0]  ws_q;

	// Derived events
	logic wr_en;
	logic wr_lane0;
	logic osc_rise;
	logic tick_rise;
	logic power_down;
	logic power_up;
	logic rollover;
	logic century_evt;
	logic fail_set;
	logic fail_rise;

	assign osc_rise   = osc_s & ~osc_prev_q;
	assign tick_rise  = tick_s & ~tick_prev_q;
	assign power_down = ~pwr_s & pwr_prev_q;
	assign power_up   = pwr_s & ~pwr_prev_q;

	assign wr_en    = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	assign wr_lane0 = wr_en & ws_q[0];

	// Halted oscillator stops the year count
	assign rollover = tick_rise & ~halt_q &
		(year_q == {`RTCS_BCD_NINE, `RTCS_BCD_NINE});
	assign century_evt = rollover & cte_q;

	// Halt bit, low supply and disturbance all mark the time suspect
	assign fail_set  = halt_q | low_s | dist_s;
	assign fail_rise = fail_set & ~fail_q;

	// Edge history
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			osc_prev_q  <= 1'h0;
			tick_prev_q <= 1'h0;
			pwr_prev_q  <= 1'h0;
		end else begin
			osc_prev_q  <= osc_s;
			tick_prev_q <= tick_s;
			pwr_prev_q  <= pwr_s;
		end
	end

	// Century enable and century flag
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			cte_q     <= `RTCS_RST_CTE;
			century_q <= `RTCS_RST_CENTURY;
		end else begin
			if (wr_lane0 && wa_q == `RTCS_OFS_CTRL) begin
				cte_q     <= wd_q[`RTCS_CTRL_CTE];
				// Toggle lands on the freshly written value
				century_q <= wd_q[`RTCS_CTRL_CENTURY] ^ century_evt;
			end else if (century_evt) begin
				century_q <= ~century_q;
			end
		end
	end

	// Halt, pin level, test select
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			halt_q  <= `RTCS_RST_HALT;
			level_q <= `RTCS_RST_LEVEL;
			ftest_q <= `RTCS_RST_FTEST;
		end else begin
			if (wr_lane0 && wa_q == `RTCS_OFS_CTRL) begin
				halt_q  <= wd_q[`RTCS_CTRL_HALT];
				level_q <= wd_q[`RTCS_CTRL_LEVEL];
			end
			// Power loss or power return beats a host write in the same cycle
			if (power_down || power_up) begin
				ftest_q <= 1'h0;
			end else if (wr_lane0 && wa_q == `RTCS_OFS_CTRL) begin
				ftest_q <= wd_q[`RTCS_CTRL_FTEST];
			end
		end
	end

	// Oscillator fail flag: set wins over a host clear
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			fail_q <= `RTCS_RST_FAIL;
		end else if (fail_set) begin
			fail_q <= 1'h1;
		end else if (wr_lane0 && wa_q == `RTCS_OFS_CTRL) begin
			fail_q <= wd_q[`RTCS_CTRL_FAIL];
		end
	end

	// BCD year counter
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			year_q <= `RTCS_RST_YEAR;
		end else if (wr_lane0 && wa_q == `RTCS_OFS_YEAR) begin
			year_q <= wd_q[7:0];
		end else if (tick_rise && !halt_q) begin
			if (year_q[3:0] != `RTCS_BCD_NINE) begin
				year_q[3:0] <= year_q[3:0] + `RTCS_BCD_ONE;
			end else begin
				year_q[3:0] <= `RTCS_BCD_ZERO;
				if (year_q[7:4] == `RTCS_BCD_NINE) begin
					year_q[7:4] <= `RTCS_BCD_ZERO;
				end else begin
					year_q[7:4] <= year_q[7:4] + `RTCS_BCD_ONE;
				end
			end
		end
	end

	// Test square wave, straight off the oscillator, no calibration path
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			div_q    <= '0;
			square_q <= 1'h0;
		end else if (halt_q) begin
			div_q <= '0;
		end else if (osc_rise) begin
			if (div_q == DIV_LAST) begin
				div_q    <= '0;
				square_q <= ~square_q;
			end else begin
				div_q <= div_q + `RTCS_DIV_W'(1);
			end
		end
	end

	// Pin source and open-drain drive
	rtcs_pkg::rtcs_pin_mode_t pin_mode;

	always_comb begin
		if (!ftest_q) begin
			pin_mode = rtcs_pkg::RTCS_PIN_LEVEL;
		end else if (!halt_q) begin
			pin_mode = rtcs_pkg::RTCS_PIN_SQUARE;
		end else begin
			pin_mode = rtcs_pkg::RTCS_PIN_RELEASED;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			test_output_pin_oe <= ~`RTCS_RST_LEVEL;
		end else begin
			unique case (pin_mode)
				rtcs_pkg::RTCS_PIN_LEVEL: begin
					test_output_pin_oe <= ~level_q;
				end
				rtcs_pkg::RTCS_PIN_SQUARE: begin
					test_output_pin_oe <= square_q;
				end
				rtcs_pkg::RTCS_PIN_RELEASED: begin
					test_output_pin_oe <= 1'h0;
				end
				default: begin
					test_output_pin_oe <= 1'h0;
				end
			endcase
		end
	end

	// Open drain only ever pulls low
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			test_output_pin_o <= 1'h0;
		end else begin
			test_output_pin_o <= 1'h0;
		end
	end

	// Interrupt status, mask and line; set wins over write-one-clear
	logic [`RTCS_IRQ_W-1:0] stat_set;
	logic [`RTCS_IRQ_W-1:0] stat_clr;

	always_comb begin
		stat_set = '0;
		stat_set[`RTCS_IRQ_CENTURY] = century_evt;
		stat_set[`RTCS_IRQ_FAIL]    = fail_rise;
		stat_clr = '0;
		if (wr_lane0 && wa_q == `RTCS_OFS_IRQ_STAT) begin
			stat_clr = wd_q[`RTCS_IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			stat_q <= '0;
			mask_q <= '0;
			irq    <= 1'h0;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | stat_set;
			if (wr_lane0 && wa_q == `RTCS_OFS_IRQ_MASK) begin
				mask_q <= wd_q[`RTCS_IRQ_W-1:0];
			end
			irq <= |(stat_q & mask_q);
		end
	end

	// Write channels: address and data taken in either order
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_awready <= 1'h1;
			s_axi_wready  <= 1'h1;
			s_axi_bvalid  <= 1'h0;
			s_axi_bresp   <= `RTCS_RESP_OKAY;
			wa_q          <= '0;
			wd_q          <= '0;
			ws_q          <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'h0;
				wa_q          <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'h0;
				wd_q         <= s_axi_wdata;
				ws_q         <= s_axi_wstrb;
			end
			if (wr_en) begin
				s_axi_bvalid <= 1'h1;
				unique case (wa_q)
					`RTCS_OFS_CTRL, `RTCS_OFS_IRQ_STAT,
					`RTCS_OFS_IRQ_MASK, `RTCS_OFS_YEAR,
					`RTCS_OFS_STATUS: s_axi_bresp <= `RTCS_RESP_OKAY;
					default: s_axi_bresp <= `RTCS_RESP_SLVERR;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'h0;
				s_axi_awready <= 1'h1;
				s_axi_wready  <= 1'h1;
			end
		end
	end

	// Read channel
	logic [31:0] rd_word;
	logic        rd_hit;

	always_comb begin
		rd_word = '0;
		rd_hit  = 1'h1;
		unique case (s_axi_araddr)
			`RTCS_OFS_CTRL: begin
				rd_word[`RTCS_CTRL_CTE]     = cte_q;
				rd_word[`RTCS_CTRL_CENTURY] = century_q;
				rd_word[`RTCS_CTRL_HALT]    = halt_q;
				rd_word[`RTCS_CTRL_FTEST]   = ftest_q;
				rd_word[`RTCS_CTRL_LEVEL]   = level_q;
				rd_word[`RTCS_CTRL_FAIL]    = fail_q;
			end
			`RTCS_OFS_IRQ_STAT: rd_word[`RTCS_IRQ_W-1:0] = stat_q;
			`RTCS_OFS_IRQ_MASK: rd_word[`RTCS_IRQ_W-1:0] = mask_q;
			`RTCS_OFS_YEAR:     rd_word[7:0] = year_q;
			`RTCS_OFS_STATUS: begin
				rd_word[`RTCS_STAT_POWER]   = pwr_s;
				rd_word[`RTCS_STAT_PIN_LOW] = test_output_pin_oe;
			end
			default: rd_hit = 1'h0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid  <= 1'h0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= `RTCS_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'h0;
			s_axi_rvalid  <= 1'h1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? `RTCS_RESP_OKAY : `RTCS_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'h0;
			s_axi_arready <= 1'h1;
		end
	end

endmodule

/* rtcs_top_properties.sv */
// Bus and pin checks on the top ports of the RTC status block.
// Assumes the bind in the bench; single clock domain.
`timescale 1ns/10ps
module rtcs_top_properties (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_b,
	// Register bus
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	// Test output
	input wire logic       test_output_pin_o,
	input wire logic       test_output_pin_oe
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	chk_pin_open_drain: assert property (test_output_pin_o == 1'b0)
		else $error("test output drives high");
	chk_pin_free_boot: assert property ($rose(rst_b) |-> !test_output_pin_oe)
		else $error("test output pulled low after power-up");
	chk_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	chk_read_answer: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
		else $error("read data missing");
	chk_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_rresp_held: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rresp))
		else $error("read response dropped");
	chk_write_busy: assert property (wr_taken |=> !s_axi_awready && !s_axi_wready)
		else $error("second write taken while busy");
	chk_write_done: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
		else $error("write channel not freed");
	chk_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
endmodule

/* rtcs_far_model.sv */
// Far side of the block: crystal oscillator and open-drain pull-up.
// Assumes the oscillator period is a whole number of system cycles.
`timescale 1ns/10ps
module rtcs_far_model #(
	parameter int OSC_CYC = 8
) (
	// Oscillator
	output logic       osc_clk_pin,
	// Open-drain pin
	input  wire logic  pin_o,
	input  wire logic  pin_oe,
	output logic       pin_level
);
	// Free running; crystal never stops in this model
	initial begin
		osc_clk_pin = 1'b0;
		#1;
		forever #(OSC_CYC * 2.5) osc_clk_pin = ~osc_clk_pin;
	end
	// Pull-up wins whenever the pin is released
	assign pin_level = pin_oe ? pin_o : 1'b1;
endmodule

/* rtcs_top_tb.sv */
// Self-checking bench of the RTC status block over AXI4-Lite.
// Assumes the far-side model and the property checker.
`timescale 1ns/10ps
`include "rtcs_defines.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_errors++; \
	$display("[FAIL] t=%0t got %0h exp %0h", $time, a, e); end end
module rtcs_top_tb;
	localparam int OSC = 8;
	logic clk_sys = 1'b0, rst_b = 1'b0, main_pw = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic bready = 1'b1, rready = 1'b1;
	logic awv = 1'b0, wv = 1'b0, arv = 1'b0, awr, wr_r, arr, bv, rv;
	logic irq, osc, oe, po, pin;
	logic [1:0] bresp, rresp;
	logic [2:0] ev = 3'h0;
	int n_errors = 0, compares = 0, g;
	always #2.5 clk_sys = ~clk_sys;
	rtcs_top dut (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rready), .osc_clk_pin(osc), .year_tick_pin(ev[2]),
		.supply_low_pin(ev[0]), .osc_disturb_pin(ev[1]),
		.main_power_pin(main_pw), .test_output_pin_o(po),
		.test_output_pin_oe(oe), .irq(irq));
	rtcs_far_model #(.OSC_CYC(OSC)) far (.osc_clk_pin(osc), .pin_o(po),
		.pin_oe(oe), .pin_level(pin));
	task automatic finish_test();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er = 2'h0, input int hold = 0);
		int n;
		awaddr <= a; wdata <= v; awv <= 1'b1; wv <= 1'b1;
		bready <= (hold == 0);
		for (n = 0; n < 100; n++) begin
			@(posedge clk_sys);
			if (awr) awv <= 1'b0;
			if (wr_r) wv <= 1'b0;
			if (bv && bready) break;
			// Late bready keeps the response standing a while
			if (bv && n >= hold) bready <= 1'b1;
		end
		if (n == 100) begin n_errors++; finish_test(); end
		`CHK(bresp, er)
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er = 2'h0, input int hold = 0);
		int n;
		araddr <= a; arv <= 1'b1;
		rready <= (hold == 0);
		for (n = 0; n < 100; n++) begin
			@(posedge clk_sys);
			if (arr) arv <= 1'b0;
			if (rv && rready) break;
			if (rv && n >= hold) rready <= 1'b1;
		end
		if (n == 100) begin n_errors++; finish_test(); end
		`CHK(rdata, e)
		`CHK(rresp, er)
	endtask
	task automatic pulse(input int i);
		ev[i] <= 1'b1;
		cyc(4);
		ev[i] <= 1'b0;
		cyc(6);
	endtask
	task automatic gap(output int n);
		logic p;
		p = oe;
		for (n = 0; n < 2000 && oe === p; n++) @(posedge clk_sys);
		if (n == 2000) begin n_errors++; finish_test(); end
	endtask
	initial begin
		cyc(10);
		rst_b <= 1'b1;
		cyc(1);
		rc(`RTCS_OFS_CTRL, 32'h30);
		rc(8'h20, 32'h0, `RTCS_RESP_SLVERR);
		wr(8'h20, 32'h1, `RTCS_RESP_SLVERR);
		wr(`RTCS_OFS_CTRL, 32'h20);
		cyc(2);
		`CHK(pin, 1'b0)
		rc(`RTCS_OFS_STATUS, 32'h3);
		wr(`RTCS_OFS_CTRL, 32'h30);
		cyc(2);
		`CHK(pin, 1'b1)
		wr(`RTCS_OFS_IRQ_MASK, 32'h3, `RTCS_RESP_OKAY, 2);
		wr(`RTCS_OFS_CTRL, 32'h10);
		rc(`RTCS_OFS_CTRL, 32'h10, `RTCS_RESP_OKAY, 2);
		for (int i = 0; i < 2; i++) begin
			pulse(i);
			rc(`RTCS_OFS_CTRL, 32'h30);
			`CHK(irq, 1'b1)
			wr(`RTCS_OFS_IRQ_STAT, 32'h2);
			cyc(2);
			`CHK(irq, 1'b0)
			wr(`RTCS_OFS_CTRL, 32'h10);
		end
		// Halt then restart, as a host does on a late failure
		wr(`RTCS_OFS_CTRL, 32'h14);
		wr(`RTCS_OFS_CTRL, 32'h10);
		rc(`RTCS_OFS_CTRL, 32'h30);
		wr(`RTCS_OFS_CTRL, 32'h10);
		rc(`RTCS_OFS_CTRL, 32'h10);
		wr(`RTCS_OFS_IRQ_STAT, 32'h3);
		wr(`RTCS_OFS_YEAR, 32'h99);
		wr(`RTCS_OFS_CTRL, 32'h11);
		pulse(2);
		rc(`RTCS_OFS_YEAR, 32'h00);
		rc(`RTCS_OFS_CTRL, 32'h13);
		rc(`RTCS_OFS_IRQ_STAT, 32'h1);
		wr(`RTCS_OFS_YEAR, 32'h99);
		wr(`RTCS_OFS_CTRL, 32'h12);
		pulse(2);
		rc(`RTCS_OFS_CTRL, 32'h12);
		wr(`RTCS_OFS_CTRL, 32'h18);
		gap(g);
		gap(g);
		`CHK(g, 32 * OSC)
		main_pw <= 1'b0;
		cyc(6);
		rc(`RTCS_OFS_CTRL, 32'h10);
		rc(`RTCS_OFS_STATUS, 32'h0);
		wr(`RTCS_OFS_CTRL, 32'h18);
		main_pw <= 1'b1;
		cyc(6);
		rc(`RTCS_OFS_CTRL, 32'h10);
		finish_test();
	end
endmodule
bind rtcs_top rtcs_top_properties chk (.clk_sys, .rst_b, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .test_output_pin_o,
	.test_output_pin_oe);
